// ### rtl/pin_ctrl_if.sv
// Control and status carried between the register block and the pin mux
`timescale 1ns/1ps
interface pin_ctrl_if;
	video_pin_pkg::video_mode_type video_mode;
	logic                          ext_clock_gen;
	logic [2:0]                    memory_clock_select;
	logic [5:0]                    pm_code;
	logic                          sck_release;
	logic                          sck_level;
	logic                          line_start;
	logic                          frame_start;

	modport ctrl (
		output video_mode,
		output ext_clock_gen,
		output memory_clock_select,
		output pm_code,
		output sck_release,
		input  sck_level,
		input  line_start,
		input  frame_start
	);

	modport mux (
		input  video_mode,
		input  ext_clock_gen,
		input  memory_clock_select,
		input  pm_code,
		input  sck_release,
		output sck_level,
		output line_start,
		output frame_start
	);
endinterface

// ### rtl/video_pin_mux.sv
// Pin direction, drive value and input sampling for the video port pins
`timescale 1ns/1ps
`include "video_pin_regs.svh"
module video_pin_mux (
	input  wire logic aclk,
	input  wire logic aresetn,
	pin_ctrl_if.mux   ctl,
	input  wire logic external_video_select,
	input  wire logic internal_blank_n,
	input  wire logic internal_hsync_n,
	input  wire logic internal_vsync_n,
	input  wire logic blank_line_pin_i,
	output wire logic blank_line_pin_o,
	output wire logic blank_line_pin_oe,
	output wire logic horiz_sync_pin_o,
	output wire logic horiz_sync_pin_oe,
	output wire logic vert_sync_pin_o,
	output wire logic vert_sync_pin_oe,
	input  wire logic frame_ref_or_clksel_pin_i,
	output wire logic frame_ref_or_clksel_pin_o,
	output wire logic frame_ref_or_clksel_pin_oe,
	input  wire logic serial_clock_pin_i,
	output wire logic serial_clock_pin_o,
	output wire logic serial_clock_pin_oe,
	output wire logic display_blank_n
);
	typedef struct packed {
		logic blank_o, blank_oe, hs_o, hs_oe, vs_o, vs_oe;
		logic fr_o, fr_oe, sck_oe, disp_n;
		logic blank_prev, frame_prev, line_start, frame_start, sck_level;
	} pin_state_type;

	pin_state_type s_reg;
	pin_state_type s_next;
	logic          fc;
	logic          dec;
	logic          low_active;

	// Active edge of a reference input; MPEG references are active low,
	// the media port and 16-bit decoder references active high
	function automatic logic edge_hit(input logic prev, input logic cur,
		input logic low);
		edge_hit = low ? (prev && !cur) : (!prev && cur);
	endfunction

	function automatic logic pm_on(input logic [5:0] pm, input int lsb);
		pm_on = pm[lsb +: 2] != `PM_OFF_CODE;
	endfunction

	always_comb begin
		fc = ctl.video_mode == video_pin_pkg::MODE_FEATURE;
		dec = ctl.video_mode == video_pin_pkg::MODE_DECODER16 ||
			ctl.video_mode == video_pin_pkg::MODE_MPEG;
		low_active = ctl.video_mode == video_pin_pkg::MODE_MPEG;
		s_next = s_reg;
		s_next.blank_o = internal_blank_n;
		s_next.blank_oe = fc && external_video_select &&
			pm_on(ctl.pm_code, `PM_BLANK_LSB);
		s_next.disp_n = (fc && !external_video_select) ?
			blank_line_pin_i : internal_blank_n;
		s_next.hs_o = internal_hsync_n;
		s_next.hs_oe = (fc && external_video_select &&
			pm_on(ctl.pm_code, `PM_HSYNC_LSB)) || dec;
		s_next.vs_o = internal_vsync_n;
		s_next.vs_oe = (fc && external_video_select &&
			pm_on(ctl.pm_code, `PM_VSYNC_LSB)) || dec;
		s_next.fr_oe = ctl.ext_clock_gen;
		s_next.fr_o = ctl.memory_clock_select[1];
		s_next.sck_oe = !ctl.sck_release;
		s_next.sck_level = serial_clock_pin_i;
		s_next.blank_prev = blank_line_pin_i;
		s_next.frame_prev = frame_ref_or_clksel_pin_i;
		s_next.line_start = !fc && edge_hit(s_reg.blank_prev,
			blank_line_pin_i, low_active);
		s_next.frame_start = !fc && !ctl.ext_clock_gen &&
			edge_hit(s_reg.frame_prev, frame_ref_or_clksel_pin_i,
			low_active);
		if (!aresetn) begin
			s_next = '0;
			s_next.hs_o = 1'b1;
			s_next.vs_o = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		s_reg <= s_next;
	end

	assign blank_line_pin_o           = s_reg.blank_o;
	assign blank_line_pin_oe          = s_reg.blank_oe;
	assign horiz_sync_pin_o           = s_reg.hs_o;
	assign horiz_sync_pin_oe          = s_reg.hs_oe;
	assign vert_sync_pin_o            = s_reg.vs_o;
	assign vert_sync_pin_oe           = s_reg.vs_oe;
	assign frame_ref_or_clksel_pin_o  = s_reg.fr_o;
	assign frame_ref_or_clksel_pin_oe = s_reg.fr_oe;
	// Open drain: the pin is only ever pulled low
	assign serial_clock_pin_o         = 1'b0;
	assign serial_clock_pin_oe        = s_reg.sck_oe;
	assign display_blank_n            = s_reg.disp_n;
	assign ctl.sck_level              = s_reg.sck_level;
	assign ctl.line_start             = s_reg.line_start;
	assign ctl.frame_start            = s_reg.frame_start;

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence fc_drive_s;
		fc && external_video_select;
	endsequence

	a_blank_off: assert property (
		fc_drive_s and (ctl.pm_code[1:0] == 2'h3) |=> !blank_line_pin_oe)
		else $error("blank pin driven while blank field off");
	a_blank_drive: assert property (
		fc_drive_s and (ctl.pm_code[1:0] != 2'h3) |=> blank_line_pin_oe
		&& display_blank_n == $past(internal_blank_n))
		else $error("blank pin not driven from internal blank");
	a_blank_input: assert property (
		fc && !external_video_select |=> !blank_line_pin_oe
		&& display_blank_n == $past(blank_line_pin_i))
		else $error("feature connector blank input not used");
	a_line_pulse: assert property (
		ctl.video_mode == video_pin_pkg::MODE_MEDIA_PORT
		&& !blank_line_pin_i ##1 blank_line_pin_i
		&& $stable(ctl.video_mode) |=> ctl.line_start ##1 !ctl.line_start)
		else $error("line reference edge not reported once");
	a_hsync_oe: assert property (
		fc && (!external_video_select || ctl.pm_code[3:2] == 2'h3)
		|=> !horiz_sync_pin_oe)
		else $error("horizontal sync driven while disabled");
	a_vsync_oe: assert property (
		fc_drive_s and (ctl.pm_code[5:4] != 2'h3) |=> vert_sync_pin_oe)
		else $error("vertical sync not driven");
	a_sync_dec: assert property (
		dec |=> horiz_sync_pin_oe && vert_sync_pin_oe)
		else $error("sync outputs off in decoder mode");
	a_clksel: assert property (
		ctl.ext_clock_gen |=> frame_ref_or_clksel_pin_oe &&
		frame_ref_or_clksel_pin_o == $past(ctl.memory_clock_select[1]))
		else $error("clock select bit not driven");
	a_frame_in: assert property (
		!ctl.ext_clock_gen |=> !frame_ref_or_clksel_pin_oe)
		else $error("frame reference pin driven with internal clock");
	a_sck_drain: assert property (
		!ctl.sck_release |=> serial_clock_pin_oe && !serial_clock_pin_o)
		else $error("serial clock not pulled low");
	a_fc_tristate: assert property (
		fc && !external_video_select |=> !horiz_sync_pin_oe
		&& !vert_sync_pin_oe)
		else $error("pins driven with direction select low");
endmodule

// ### rtl/video_pin_pkg.sv
// Types shared by the video port pin control modules
package video_pin_pkg;

	// Video interface selection; one function per pin at a time
	typedef enum logic [1:0] {
		MODE_FEATURE    = 2'h0,
		MODE_MEDIA_PORT = 2'h1,
		MODE_DECODER16  = 2'h2,
		MODE_MPEG       = 2'h3
	} video_mode_type;

endpackage

// ### rtl/video_pin_regs.svh
// Register indices, byte addresses, field positions and reset values
`ifndef VIDEO_PIN_REGS_SVH
`define VIDEO_PIN_REGS_SVH

// Register indices; byte address is four times the index
`define IDX_PM           12'h026
`define IDX_IO_STATUS    12'h050
`define IDX_IO_SEQ       12'h01E
`define IDX_SERIAL       12'h31C
`define IDX_MODE         12'h040
`define ADDR_PM          12'h098
`define ADDR_IO_STATUS   12'h140
`define ADDR_IO_SEQ      12'h078
`define ADDR_SERIAL      12'hC70
`define ADDR_MODE        12'h100

// Power-management field positions and the tristate code
`define PM_BLANK_LSB     0
`define PM_HSYNC_LSB     2
`define PM_VSYNC_LSB     4
`define PM_OFF_CODE      2'h3

// Serial clock and data control bits
`define SER_CLK_DRV_BIT  0
`define SER_DAT_DRV_BIT  1
`define SER_CLK_LVL_BIT  2
`define SEQ_GP_LSB       3
`define SEQ_CLK_DRV_BIT  5
`define SEQ_DAT_DRV_BIT  6

// Mode register fields
`define MODE_SEL_LSB     0
`define MODE_EXTCLK_BIT  2
`define MODE_MCLK_LSB    4
`define MODE_EVS_BIT     8

// Reset values
`define RST_PM           6'h00
`define RST_SER_DRV      1'h1
`define RST_MODE         2'h0
`define RST_MCLK         3'h0

// Bus responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ### rtl/video_port_pin_control.sv
// Video port pin control with its AXI4-Lite register slave
`timescale 1ns/1ps
`include "video_pin_regs.svh"
// Operation
// - Feature mode, select high: blank pin driven unless its field is 11.
// - Select low: the blank pin is an input that gates the display.
// - Media port, 16-bit decoder or MPEG: blank pin marks a new scanline.
// - Feature mode: hsync driven only with select high and field not 11.
// - Feature mode: vsync driven only with select high and field not 11.
// - Both sync outputs are driven whenever a decoder interface is selected.
// - External clock generator: frame pin drives memory clock select bit 1.
// - Internal clock generator, outside feature mode: the frame pin is a frame start input.
// - Clock pin level reads at bit 2 of serial and I/O status registers.
// - Clock drive follows serial bit 0 or sequencer bit 5, last write wins.
// - Select high lets the device drive feature pins; low tristates them.
module video_port_pin_control #(
	parameter int ADDR_W = 12
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output wire logic              s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output wire logic              s_axi_wready,
	output wire logic [1:0]        s_axi_bresp,
	output wire logic              s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output wire logic              s_axi_arready,
	output wire logic [31:0]       s_axi_rdata,
	output wire logic [1:0]        s_axi_rresp,
	output wire logic              s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              external_video_select,
	input  wire logic              internal_blank_n,
	input  wire logic              internal_hsync_n,
	input  wire logic              internal_vsync_n,
	input  wire logic              blank_line_pin_i,
	output wire logic              blank_line_pin_o,
	output wire logic              blank_line_pin_oe,
	output wire logic              horiz_sync_pin_o,
	output wire logic              horiz_sync_pin_oe,
	output wire logic              vert_sync_pin_o,
	output wire logic              vert_sync_pin_oe,
	input  wire logic              frame_ref_or_clksel_pin_i,
	output wire logic              frame_ref_or_clksel_pin_o,
	output wire logic              frame_ref_or_clksel_pin_oe,
	input  wire logic              serial_clock_pin_i,
	output wire logic              serial_clock_pin_o,
	output wire logic              serial_clock_pin_oe,
	output wire logic              display_blank_n,
	output wire logic              line_start,
	output wire logic              frame_start
);
	////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic                          awready;
		logic                          aw_full;
		logic [ADDR_W-1:0]             aw_addr;
		logic                          wready;
		logic                          w_full;
		logic [7:0]                    w_byte;
		logic                          w_lane;
		logic                          bvalid;
		logic [1:0]                    bresp;
		logic                          arready;
		logic                          rvalid;
		logic [31:0]                   rdata;
		logic [1:0]                    rresp;
		logic [5:0]                    pm;
		logic                          clk_drv;
		logic                          dat_drv;
		logic [1:0]                    gp;
		video_pin_pkg::video_mode_type mode;
		logic                          ext_clk;
		logic [2:0]                    mclk;
	} bus_state_type;

	bus_state_type s_reg;
	bus_state_type s_next;
	logic          write_fire;
	logic          read_fire;
	pin_ctrl_if    ctl();

	////////////////////////////////////////////////////////////////////
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		case (a)
			`ADDR_PM, `ADDR_IO_STATUS, `ADDR_IO_SEQ, `ADDR_SERIAL,
			`ADDR_MODE: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	// Status is the pin as seen last cycle, not the programmed value,
	// so software sees a slave device stretching the clock low
	function automatic logic [31:0] read_word(
		input logic [ADDR_W-1:0] a,
		input bus_state_type     st,
		input logic              lvl,
		input logic              evs
	);
		logic [31:0] d;
		d = 32'h0000_0000;
		case (a)
			`ADDR_PM: begin
				d[5:0] = st.pm;
			end
			`ADDR_IO_STATUS: begin
				d[`SER_CLK_LVL_BIT] = lvl;
			end
			`ADDR_IO_SEQ: begin
				d[`SEQ_GP_LSB +: 2] = st.gp;
				d[`SEQ_CLK_DRV_BIT] = st.clk_drv;
				d[`SEQ_DAT_DRV_BIT] = st.dat_drv;
			end
			`ADDR_SERIAL: begin
				d[`SER_CLK_DRV_BIT] = st.clk_drv;
				d[`SER_DAT_DRV_BIT] = st.dat_drv;
				d[`SER_CLK_LVL_BIT] = lvl;
			end
			`ADDR_MODE: begin
				d[`MODE_SEL_LSB +: 2] = st.mode;
				d[`MODE_EXTCLK_BIT] = st.ext_clk;
				d[`MODE_MCLK_LSB +: 3] = st.mclk;
				d[`MODE_EVS_BIT] = evs;
			end
			default: begin
				d = 32'h0000_0000;
			end
		endcase
		read_word = d;
	endfunction

	////////////////////////////////////////////////////////////////////
	always_comb begin
		s_next = s_reg;
		write_fire = 1'b0;
		read_fire = s_reg.arready && s_axi_arvalid;
		if (s_reg.awready && s_axi_awvalid) begin
			s_next.aw_full = 1'b1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_reg.wready && s_axi_wvalid) begin
			s_next.w_full = 1'b1;
			s_next.w_byte = s_axi_wdata[7:0];
			s_next.w_lane = s_axi_wstrb[0];
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end
		// Address and data may arrive in either order; the write is done
		// once both are held and the previous response has been taken
		if (s_next.aw_full && s_next.w_full && !s_next.bvalid) begin
			write_fire = 1'b1;
			s_next.aw_full = 1'b0;
			s_next.w_full = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = is_mapped(s_next.aw_addr) ?
				`RESP_OKAY : `RESP_SLVERR;
			if (s_next.w_lane) begin
				case (s_next.aw_addr)
					`ADDR_PM: begin
						s_next.pm = s_next.w_byte[5:0];
					end
					`ADDR_SERIAL: begin
						s_next.clk_drv = s_next.w_byte[`SER_CLK_DRV_BIT];
						s_next.dat_drv = s_next.w_byte[`SER_DAT_DRV_BIT];
					end
					`ADDR_IO_SEQ: begin
						s_next.gp = s_next.w_byte[`SEQ_GP_LSB +: 2];
						s_next.clk_drv = s_next.w_byte[`SEQ_CLK_DRV_BIT];
						s_next.dat_drv = s_next.w_byte[`SEQ_DAT_DRV_BIT];
					end
					`ADDR_MODE: begin
						s_next.mode = video_pin_pkg::video_mode_type'(
							s_next.w_byte[`MODE_SEL_LSB +: 2]);
						s_next.ext_clk = s_next.w_byte[`MODE_EXTCLK_BIT];
						s_next.mclk = s_next.w_byte[`MODE_MCLK_LSB +: 3];
					end
					default: begin
						s_next.pm = s_reg.pm;
					end
				endcase
			end
		end
		s_next.awready = !s_next.aw_full && !s_next.bvalid;
		s_next.wready = !s_next.w_full && !s_next.bvalid;
		if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end
		if (read_fire) begin
			s_next.rvalid = 1'b1;
			s_next.rdata = read_word(s_axi_araddr, s_reg,
				ctl.sck_level, external_video_select);
			s_next.rresp = is_mapped(s_axi_araddr) ?
				`RESP_OKAY : `RESP_SLVERR;
		end
		s_next.arready = !s_next.rvalid;
		if (!aresetn) begin
			s_next = '0;
			s_next.pm = `RST_PM;
			s_next.clk_drv = `RST_SER_DRV;
			s_next.dat_drv = `RST_SER_DRV;
			s_next.mode = video_pin_pkg::video_mode_type'(`RST_MODE);
			s_next.mclk = `RST_MCLK;
		end
	end

	always_ff @(posedge aclk) begin
		s_reg <= s_next;
	end

	////////////////////////////////////////////////////////////////////
	assign s_axi_awready = s_reg.awready;
	assign s_axi_wready  = s_reg.wready;
	assign s_axi_bvalid  = s_reg.bvalid;
	assign s_axi_bresp   = s_reg.bresp;
	assign s_axi_arready = s_reg.arready;
	assign s_axi_rvalid  = s_reg.rvalid;
	assign s_axi_rdata   = s_reg.rdata;
	assign s_axi_rresp   = s_reg.rresp;

	assign ctl.video_mode          = s_reg.mode;
	assign ctl.ext_clock_gen       = s_reg.ext_clk;
	assign ctl.memory_clock_select = s_reg.mclk;
	assign ctl.pm_code             = s_reg.pm;
	assign ctl.sck_release         = s_reg.clk_drv;
	assign line_start              = ctl.line_start;
	assign frame_start             = ctl.frame_start;

	video_pin_mux u_mux (
		.aclk                       (aclk),
		.aresetn                    (aresetn),
		.ctl                        (ctl.mux),
		.external_video_select      (external_video_select),
		.internal_blank_n           (internal_blank_n),
		.internal_hsync_n           (internal_hsync_n),
		.internal_vsync_n           (internal_vsync_n),
		.blank_line_pin_i           (blank_line_pin_i),
		.blank_line_pin_o           (blank_line_pin_o),
		.blank_line_pin_oe          (blank_line_pin_oe),
		.horiz_sync_pin_o           (horiz_sync_pin_o),
		.horiz_sync_pin_oe          (horiz_sync_pin_oe),
		.vert_sync_pin_o            (vert_sync_pin_o),
		.vert_sync_pin_oe           (vert_sync_pin_oe),
		.frame_ref_or_clksel_pin_i  (frame_ref_or_clksel_pin_i),
		.frame_ref_or_clksel_pin_o  (frame_ref_or_clksel_pin_o),
		.frame_ref_or_clksel_pin_oe (frame_ref_or_clksel_pin_oe),
		.serial_clock_pin_i         (serial_clock_pin_i),
		.serial_clock_pin_o         (serial_clock_pin_o),
		.serial_clock_pin_oe        (serial_clock_pin_oe),
		.display_blank_n            (display_blank_n)
	);

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence serial_read_s;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == `ADDR_SERIAL;
	endsequence

	sequence status_read_s;
		s_axi_arvalid && s_axi_arready &&
		s_axi_araddr == `ADDR_IO_STATUS;
	endsequence

	a_serial_level: assert property (
		serial_read_s |=> s_axi_rvalid &&
		s_axi_rdata[2] == $past(ctl.sck_level))
		else $error("serial register does not show clock level");
	a_status_level: assert property (
		status_read_s |=> s_axi_rvalid &&
		s_axi_rdata[2] == $past(ctl.sck_level) && s_axi_rresp == 2'h0)
		else $error("status register does not show clock level");
	a_clk_from_write: assert property (
		$changed(s_reg.clk_drv) |-> $past(write_fire))
		else $error("serial clock drive changed without a write");
	a_seq_write: assert property (
		write_fire && s_next.w_lane && s_next.aw_addr == `ADDR_IO_SEQ
		|=> ##1 serial_clock_pin_oe == !$past(s_next.w_byte[5], 2))
		else $error("sequencer bit 5 does not steer the serial clock");
	a_write_resp: assert property (
		write_fire |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
		else $error("write response missing");
	a_read_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
endmodule

// ### sim/pin_partner.sv
// Far-side model of the video pins: card or decoder, and the clock pull-up
`timescale 1ns/1ps
module pin_partner (
	input  wire logic line_level,
	input  wire logic frame_level,
	input  wire logic blank_o,
	input  wire logic blank_oe,
	input  wire logic frame_o,
	input  wire logic frame_oe,
	input  wire logic sck_o,
	input  wire logic sck_oe,
	output wire logic blank_i,
	output wire logic frame_i,
	output wire logic sck_i
);
	// Far side drives a shared line only while the device lets go of it
	assign blank_i = blank_oe ? blank_o : line_level;
	assign frame_i = frame_oe ? frame_o : frame_level;
	// Pull-up lifts the clock line whenever nobody pulls it low
	assign sck_i = (sck_oe && !sck_o) ? 1'b0 : 1'b1;
endmodule

// ### sim/tb.sv
// Self-checking bench for the video port pin control block
`timescale 1ns/1ps
`include "video_pin_regs.svh"
module tb;
	logic        aclk, aresetn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d, lfsr;
	logic [1:0]  bresp, rresp, r;
	logic        evs, ib_n, ih_n, iv_n, line_lvl, frame_lvl, bl_i, bl_o;
	logic        bl_oe, hs_o, hs_oe, vs_o, vs_oe, fr_i, fr_o, fr_oe;
	logic        sc_i, sc_o, sc_oe, disp_n, ls, fs, ap, wp, f;
	logic [3:0]  pl, pf;
	int          miscompares, cmp_count, cyc, pm, mode, ext, mclk, n, i;

	video_port_pin_control video_port_pin_control_inst (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.external_video_select(evs), .internal_blank_n(ib_n),
		.internal_hsync_n(ih_n), .internal_vsync_n(iv_n),
		.blank_line_pin_i(bl_i), .blank_line_pin_o(bl_o),
		.blank_line_pin_oe(bl_oe), .horiz_sync_pin_o(hs_o),
		.horiz_sync_pin_oe(hs_oe), .vert_sync_pin_o(vs_o),
		.vert_sync_pin_oe(vs_oe), .frame_ref_or_clksel_pin_i(fr_i),
		.frame_ref_or_clksel_pin_o(fr_o), .frame_ref_or_clksel_pin_oe(fr_oe),
		.serial_clock_pin_i(sc_i), .serial_clock_pin_o(sc_o),
		.serial_clock_pin_oe(sc_oe), .display_blank_n(disp_n),
		.line_start(ls), .frame_start(fs));
	pin_partner pin_partner_inst (.line_level(line_lvl),
		.frame_level(frame_lvl), .blank_o(bl_o), .blank_oe(bl_oe),
		.frame_o(fr_o), .frame_oe(fr_oe), .sck_o(sc_o), .sck_oe(sc_oe),
		.blank_i(bl_i), .frame_i(fr_i), .sck_i(sc_i));

	initial begin
		aclk = 0;
		forever #2 aclk = ~aclk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("compares %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [31:0] lfsr_next(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// Channels are released one by one as each is taken
	task automatic axi_wr(logic [11:0] a, logic [31:0] dt);
		@(posedge aclk);
		awaddr <= a;
		wdata <= dt;
		{awv, wv, br} <= 3'h7;
		{ap, wp} = 2'h3;
		while (ap || wp) begin
			@(posedge aclk);
			if (awr === 1'b1) ap = 1'b0;
			if (wr === 1'b1) wp = 1'b0;
			awv <= ap;
			wv <= wp;
		end
		while (bv !== 1'b1) @(posedge aclk);
		r = bresp;
		br <= 0;
	endtask
	task automatic axi_rd(logic [11:0] a);
		@(posedge aclk);
		araddr <= a;
		{arv, rr} <= 2'h3;
		do @(posedge aclk); while (arr !== 1'b1);
		arv <= 0;
		do @(posedge aclk); while (rv !== 1'b1);
		{d, r} = {rdata, rresp};
		rr <= 0;
	endtask
	task automatic set_cfg();
		axi_wr(`ADDR_PM, pm);
		axi_wr(`ADDR_MODE, mode | ext << 2 | mclk << 4);
		check("cfg_resp", r, `RESP_OKAY);
		repeat (3) @(posedge aclk);
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			end_of_test();
		end
	end
	initial begin
		{aresetn, awv, wv, br, arv, rr, evs, line_lvl, frame_lvl} = '0;
		{awaddr, araddr, wdata, pm, mode, ext, mclk} = '0;
		{ib_n, ih_n, iv_n} = 3'h7;
		lfsr = 32'h6AB5;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		repeat (2) @(posedge aclk);
		check("oe_reset", {bl_oe, hs_oe, vs_oe, fr_oe, sc_oe}, 0);
		$display("reset test done");
		for (i = 0; i < 16; i++) begin
			lfsr = lfsr_next(lfsr);
			pm = lfsr[5:0];
			mode = (i < 6) ? 0 : lfsr[9:8];
			{evs, ib_n, ih_n, iv_n, line_lvl} <= lfsr[16:12];
			set_cfg();
			f = (mode == 0) && evs;
			check("blank_oe", bl_oe, f && pm[1:0] != 3);
			check("hsync_oe", hs_oe, (f && pm[3:2] != 3) || mode >= 2);
			check("vsync_oe", vs_oe, (f && pm[5:4] != 3) || mode >= 2);
			if (f) check("hsync_o", hs_o, ih_n);
			if (f) check("vsync_o", vs_o, iv_n);
			if (f) check("blank_o", bl_o, ib_n);
			if (mode == 0) check("disp", disp_n, evs ? ib_n : line_lvl);
		end
		$display("pin direction test done");
		ext = 1;
		for (mclk = 0; mclk < 8; mclk++) begin
			set_cfg();
			check("frame_oe", fr_oe, 1);
			check("frame_o", fr_o, mclk[1]);
		end
		$display("clock select test done");
		{ext, mclk} = '0;
		{line_lvl, frame_lvl} <= 2'h0;
		for (mode = 0; mode < 4; mode++) begin
			set_cfg();
			for (n = 0; n < 2; n++) begin
				{pl, pf} = '0;
				{line_lvl, frame_lvl} <= {2{n == 0}};
				repeat (6) begin
					@(posedge aclk);
					{pl, pf} = {pl + ls, pf + fs};
				end
				f = (mode != 0) && (n == (mode == 3));
				check("line_pulses", pl, f);
				check("frame_pulses", pf, f);
				check("frame_oe", fr_oe, 0);
			end
		end
		$display("reference pulse test done");
		// The second step tells last-write-wins from an and of bits
		for (i = 0; i < 4; i++) begin
			n = i[0] ^ i[1];
			axi_wr(i[0] ? `ADDR_IO_SEQ : `ADDR_SERIAL, i[0] ? n << 5 : n);
			repeat (3) @(posedge aclk);
			check("sck_oe", sc_oe, !n);
			check("sck_o", sc_o, 0);
			axi_rd(`ADDR_SERIAL);
			check("sck_level", d[2], n);
			axi_rd(`ADDR_IO_STATUS);
			check("sck_status", d[2], n);
		end
		$display("serial clock test done");
		axi_wr(12'hFFC, 32'hFF);
		check("bad_wr", r, `RESP_SLVERR);
		axi_rd(12'hFFC);
		check("bad_rd", d, 32'h0);
		check("bad_rresp", r, `RESP_SLVERR);
		$display("unmapped test done");
		end_of_test();
	end
endmodule
